// ==== csl_amp_model.sv ====
// Purpose: Behavioural servo amplifier group on the CAN side of the supervisor
// Assumes: Frames move as whole structs, one per accepted handshake
// Notes:   Ready can be held back four cycles to stall the sender
module csl_amp_model (
  input  wire logic                    i_ref_clk,
  input  wire csl_pkg::csl_can_frame_t i_tx_frame,
  input  wire logic                    i_tx_valid,
  output logic                         o_tx_ready,
  output csl_pkg::csl_can_frame_t      o_rx_frame,
  output logic                         o_rx_valid,
  input  wire logic                    i_slow
);
  timeunit 1ns;
  timeprecision 1ps;
  int          n_rx[6];
  logic [31:0] last[6];
  int          bad_fmt;
  int          wait_c;
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_frame = '0;
    bad_fmt    = 0;
    wait_c     = 0;
    foreach (n_rx[i]) n_rx[i] = 0;
  end
  // Take a frame, check its format, file its data under the axis
  always @(posedge i_ref_clk) begin
    if (o_tx_ready && i_tx_valid) begin
      if (i_tx_frame.ide !== 1'b0 || i_tx_frame.dlc !== 4'h4) bad_fmt++;
      else if (i_tx_frame.id < 11'h010 || i_tx_frame.id > 11'h015) bad_fmt++;
      else begin
        n_rx[i_tx_frame.id - 11'h010]++;
        last[i_tx_frame.id - 11'h010] = i_tx_frame.data;
      end
      o_tx_ready <= 1'b0;
      wait_c     <= 0;
    end else if (i_tx_valid) begin
      wait_c     <= wait_c + 1;
      o_tx_ready <= !i_slow || wait_c >= 3;
    end
  end
  // Report a position, LSB in byte 0; lines scrambled once released
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_rx_frame <= {1'b0, id, dlc, d};
    o_rx_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b0;
    o_rx_frame <= ~o_rx_frame;
  endtask
endmodule

// ==== csl_params.svh ====
`ifndef CSL_PARAMS_SVH
`define CSL_PARAMS_SVH
// Register byte offsets
`define CSL_A_CTRL      8'h00
`define CSL_A_STATUS    8'h04
`define CSL_A_WD_TMO    8'h08
`define CSL_A_SWITCH    8'h0c
`define CSL_A_SWITCH_N  8'h10
// Per-axis blocks, selected by address bits 7:5, axis by bits 4:2
`define CSL_B_CMD       3'h1
`define CSL_B_SCALE     3'h2
`define CSL_B_FBSCALE   3'h3
`define CSL_B_FB        3'h4
// Control fields
`define CSL_F_WD_EN     0
`define CSL_F_PWR_REQ   1
`define CSL_F_APP_RUN   2
`define CSL_F_BOOT_OK   3
`define CSL_F_BUS_ERR   4
`define CSL_F_SEND_EN   8
`define CSL_CTRL_MASK   32'h0000_3f0f
// Reset values
`define CSL_RST_CTRL    32'h0000_0000
`define CSL_RST_WD_TMO  32'h0005_b8d8
`define CSL_RST_SCALE   32'h0000_0001
`define CSL_RST_FBSCALE 32'h0001_0000
// Frame format
`define CSL_CMD_ID_BASE 11'h010
`define CSL_FB_ID_BASE  11'h020
`define CSL_DLC         4'h4
// Timing
`define CSL_CLK_NS      8
`define CSL_BIT_NS      1000
`define CSL_SEND_NS     1000000
`define CSL_BLINK_NS    250000000
`endif

// ==== csl_pkg.sv ====
// Purpose: Types shared by the servo link supervisor
// Assumes: Constants come from csl_params.svh
// Notes:   Frame data byte 0 is the least significant byte
package csl_pkg;
  typedef struct packed {
    logic        ide;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [31:0] data;
  } csl_can_frame_t;

  typedef struct packed {
    logic [5:0] upper;
    logic [5:0] lower;
    logic [5:0] refsw;
  } csl_switch_t;

  typedef enum logic [1:0] {
    CSL_TX_IDLE = 2'b00,
    CSL_TX_SCAN = 2'b01,
    CSL_TX_SEND = 2'b10
  } csl_tx_st_t;
endpackage

// ==== csl_supervisor.sv ====
// Purpose: Servo link supervisor: CAN position exchange, watchdog, power, inputs, LEDs
// Assumes: All inputs synchronous to i_ref_clk; CAN controller core takes frames
// Notes:   Positions in user units are Q16.16
//
// Design decisions made here: the strobed register port and the register offsets.
`include "csl_params.svh"
module csl_supervisor #(
  parameter int          N_AXES          = 6,
  parameter logic [31:0] SEND_PERIOD_CYC = `CSL_SEND_NS / `CSL_CLK_NS,
  parameter logic [31:0] BLINK_HALF_CYC  = `CSL_BLINK_NS / `CSL_CLK_NS
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [31:0]                  o_rdata,
  output csl_pkg::csl_can_frame_t      o_tx_frame,
  output logic                         o_tx_valid,
  input  wire logic                    i_tx_ready,
  input  wire csl_pkg::csl_can_frame_t i_rx_frame,
  input  wire logic                    i_rx_valid,
  input  wire logic                    i_can_buf_full,
  output logic                         o_can_bit_tick,
  input  wire logic [5:0]              i_reference_switch_input,
  input  wire logic [5:0]              i_lower_travel_limit,
  input  wire logic [5:0]              i_upper_travel_limit,
  input  wire logic [1:0]              i_estop,
  input  wire logic                    i_power_fault,
  input  wire logic                    i_host_bus_err,
  output logic [5:0]                   o_drive_pwr_en,
  output logic                         o_led_can,
  output logic                         o_led_error,
  output logic                         o_led_boot,
  output logic                         o_app_running_indicator
);
  localparam int BIT_CYC = (`CSL_BIT_NS + `CSL_CLK_NS - 1) / `CSL_CLK_NS;

  if (N_AXES < 1 || N_AXES > 6) $error("N_AXES must be 1 to 6");
  if (SEND_PERIOD_CYC < 32'd8 || BLINK_HALF_CYC < 32'd1) $error("Bad period");

  function automatic logic [31:0] to_counts(logic [31:0] u, logic [31:0] s);
    logic signed [63:0] p;
    p = $signed(u) * $signed(s);
    return p[47:16];
  endfunction

  function automatic logic [31:0] to_user(logic [31:0] c, logic [31:0] s);
    logic signed [63:0] p;
    p = $signed(c) * $signed(s);
    return p[31:0];
  endfunction

  // Register file state
  logic [31:0]          ctrl_q, ctrl_d, wd_tmo_q, wd_tmo_d, rdata_d;
  logic [31:0]          cmd_q [N_AXES];
  logic [31:0]          cmd_d [N_AXES];
  logic [31:0]          scale_q [N_AXES];
  logic [31:0]          scale_d [N_AXES];
  logic [31:0]          fbsc_q [N_AXES];
  logic [31:0]          fbsc_d [N_AXES];
  logic [31:0]          fb_q [N_AXES];
  logic [31:0]          fb_d [N_AXES];
  logic                 bus_err_q, bus_err_d;
  csl_pkg::csl_switch_t sw_q, sw_d;
  logic [1:0]           estop_q, estop_d;
  logic [2:0]           blk, idx;
  logic                 idx_ok, refresh;
  logic [10:0]          rx_off;
  logic [2:0]           rx_idx;
  logic                 rx_hit;
  logic [31:0]          rx_user;

  assign blk     = i_addr[7:5];
  assign idx     = i_addr[4:2];
  assign idx_ok  = idx < 3'(N_AXES);
  assign refresh = i_rd && i_addr == `CSL_A_SWITCH;
  assign rx_off  = i_rx_frame.id - `CSL_FB_ID_BASE;
  assign rx_idx  = rx_off[2:0];
  assign rx_hit  = i_rx_valid && !i_rx_frame.ide && i_rx_frame.dlc == `CSL_DLC &&
                   rx_off < 11'(N_AXES);
  assign rx_user = to_user(i_rx_frame.data, fbsc_q[rx_idx]);

  // Watchdog and power state
  logic [31:0] wd_cnt_q, wd_cnt_d;
  logic        wd_exp_q, wd_exp_d;
  logic [5:0]  pwr_d;

  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_exp_d = wd_exp_q;
    if (!ctrl_q[`CSL_F_WD_EN]) begin
      wd_cnt_d = '0;
      wd_exp_d = 1'b0;
    end else if (refresh) begin
      wd_cnt_d = '0;
      wd_exp_d = 1'b0;
    end else if (wd_cnt_q >= wd_tmo_q) begin
      wd_exp_d = 1'b1;
    end else begin
      wd_cnt_d = wd_cnt_q + 32'd1;
    end
    pwr_d = {6{ctrl_q[`CSL_F_PWR_REQ] && !wd_exp_d && !i_power_fault}};
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    wd_tmo_d  = wd_tmo_q;
    cmd_d     = cmd_q;
    scale_d   = scale_q;
    fbsc_d    = fbsc_q;
    fb_d      = fb_q;
    sw_d      = '{upper: i_upper_travel_limit, lower: i_lower_travel_limit,
                  refsw: i_reference_switch_input};
    estop_d   = i_estop;
    bus_err_d = bus_err_q;
    if (i_wr) begin
      if (i_addr == `CSL_A_CTRL) begin
        ctrl_d = i_wdata & `CSL_CTRL_MASK;
        if (i_wdata[`CSL_F_BUS_ERR]) bus_err_d = 1'b0;
      end
      if (i_addr == `CSL_A_WD_TMO) wd_tmo_d = i_wdata;
      if (idx_ok && i_addr[1:0] == 2'h0) begin
        if (blk == `CSL_B_CMD) cmd_d[idx] = i_wdata;
        if (blk == `CSL_B_SCALE) scale_d[idx] = i_wdata;
        if (blk == `CSL_B_FBSCALE) fbsc_d[idx] = i_wdata;
      end
    end
    if (i_host_bus_err) bus_err_d = 1'b1;
    if (rx_hit) fb_d[rx_idx] = rx_user;
    rdata_d = '0;
    if (i_rd) begin
      unique case (i_addr)
        `CSL_A_CTRL:     rdata_d = ctrl_q | (32'(bus_err_q) << `CSL_F_BUS_ERR);
        `CSL_A_STATUS:   rdata_d = {24'h0, ~estop_q, estop_q, 1'b0, o_drive_pwr_en[0],
                                    i_power_fault, wd_exp_q};
        `CSL_A_WD_TMO:   rdata_d = wd_tmo_q;
        `CSL_A_SWITCH:   rdata_d = {14'h0, sw_q};
        `CSL_A_SWITCH_N: rdata_d = {14'h0, ~sw_q};
        default: begin
          if (idx_ok && i_addr[1:0] == 2'h0) begin
            if (blk == `CSL_B_CMD) rdata_d = cmd_q[idx];
            if (blk == `CSL_B_SCALE) rdata_d = scale_q[idx];
            if (blk == `CSL_B_FBSCALE) rdata_d = fbsc_q[idx];
            if (blk == `CSL_B_FB) rdata_d = fb_q[idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ctrl_q         <= `CSL_RST_CTRL;
      wd_tmo_q       <= `CSL_RST_WD_TMO;
      cmd_q          <= '{default: 32'h0};
      scale_q        <= '{default: `CSL_RST_SCALE};
      fbsc_q         <= '{default: `CSL_RST_FBSCALE};
      fb_q           <= '{default: 32'h0};
      sw_q           <= '0;
      estop_q        <= 2'h0;
      bus_err_q      <= 1'b0;
      o_rdata        <= 32'h0;
      wd_cnt_q       <= 32'h0;
      wd_exp_q       <= 1'b0;
      o_drive_pwr_en <= 6'h0;
    end else begin
      ctrl_q         <= ctrl_d;
      wd_tmo_q       <= wd_tmo_d;
      cmd_q          <= cmd_d;
      scale_q        <= scale_d;
      fbsc_q         <= fbsc_d;
      fb_q           <= fb_d;
      sw_q           <= sw_d;
      estop_q        <= estop_d;
      bus_err_q      <= bus_err_d;
      o_rdata        <= rdata_d;
      wd_cnt_q       <= wd_cnt_d;
      wd_exp_q       <= wd_exp_d;
      o_drive_pwr_en <= pwr_d;
    end
  end

  // Command frame scheduler
  csl_pkg::csl_tx_st_t     st_q, st_d;
  logic [2:0]              ax_q, ax_d;
  logic [31:0]             per_q, per_d;
  logic [6:0]              bit_q, bit_d;
  logic                    tick_d, txv_d;
  csl_pkg::csl_can_frame_t txf_d;
  logic                    send_en;
  logic [31:0]             tx_counts;

  assign send_en   = ctrl_q[`CSL_F_SEND_EN + 32'(ax_q)];
  assign tx_counts = to_counts(cmd_q[ax_q], scale_q[ax_q]);

  always_comb begin
    st_d   = st_q;
    ax_d   = ax_q;
    txv_d  = o_tx_valid;
    txf_d  = o_tx_frame;
    per_d  = (per_q >= SEND_PERIOD_CYC - 32'd1) ? 32'h0 : per_q + 32'd1;
    tick_d = bit_q == 7'(BIT_CYC - 1);
    bit_d  = tick_d ? 7'h0 : bit_q + 7'h1;
    unique case (st_q)
      csl_pkg::CSL_TX_IDLE: begin
        ax_d = 3'h0;
        if (per_q == 32'h0) st_d = csl_pkg::CSL_TX_SCAN;
      end
      csl_pkg::CSL_TX_SCAN: begin
        if (send_en) begin
          txv_d = 1'b1;
          txf_d = '{ide: 1'b0, id: `CSL_CMD_ID_BASE + 11'(ax_q),
                    dlc: `CSL_DLC, data: tx_counts};
          st_d  = csl_pkg::CSL_TX_SEND;
        end else if (ax_q == 3'(N_AXES - 1)) begin
          st_d = csl_pkg::CSL_TX_IDLE;
        end else begin
          ax_d = ax_q + 3'h1;
        end
      end
      csl_pkg::CSL_TX_SEND: begin
        if (i_tx_ready) begin
          txv_d = 1'b0;
          ax_d  = ax_q + 3'h1;
          st_d  = (ax_q == 3'(N_AXES - 1)) ? csl_pkg::CSL_TX_IDLE : csl_pkg::CSL_TX_SCAN;
        end
      end
      default: st_d = csl_pkg::CSL_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q           <= csl_pkg::CSL_TX_IDLE;
      ax_q           <= 3'h0;
      per_q          <= 32'h0;
      bit_q          <= 7'h0;
      o_can_bit_tick <= 1'b0;
      o_tx_valid     <= 1'b0;
      o_tx_frame     <= '0;
    end else begin
      st_q           <= st_d;
      ax_q           <= ax_d;
      per_q          <= per_d;
      bit_q          <= bit_d;
      o_can_bit_tick <= tick_d;
      o_tx_valid     <= txv_d;
      o_tx_frame     <= txf_d;
    end
  end

  // Status LEDs
  logic [31:0] blk_cnt_q, blk_cnt_d;
  logic        blink_q, blink_d, act_q, act_d;
  logic        led_can_d, led_err_d, led_boot_d, led_app_d;

  always_comb begin
    blk_cnt_d = blk_cnt_q + 32'd1;
    blink_d   = blink_q;
    act_d     = act_q;
    if (blk_cnt_q >= BLINK_HALF_CYC - 32'd1) begin
      blk_cnt_d = 32'h0;
      blink_d   = !blink_q;
      act_d     = 1'b0;
    end
    if ((o_tx_valid && i_tx_ready) || i_rx_valid) act_d = 1'b1;
    led_can_d  = i_can_buf_full || (act_q && blink_q);
    led_err_d  = wd_exp_q || (bus_err_q && blink_q);
    led_boot_d = ctrl_q[`CSL_F_BOOT_OK];
    led_app_d  = ctrl_q[`CSL_F_APP_RUN] && blink_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      blk_cnt_q               <= 32'h0;
      blink_q                 <= 1'b0;
      act_q                   <= 1'b0;
      o_led_can               <= 1'b0;
      o_led_error             <= 1'b0;
      o_led_boot              <= 1'b0;
      o_app_running_indicator <= 1'b0;
    end else begin
      blk_cnt_q               <= blk_cnt_d;
      blink_q                 <= blink_d;
      act_q                   <= act_d;
      o_led_can               <= led_can_d;
      o_led_error             <= led_err_d;
      o_led_boot              <= led_boot_d;
      o_app_running_indicator <= led_app_d;
    end
  end

  // Checks
  a_cmd_frame_id: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_tx_valid |-> o_tx_frame.id == `CSL_CMD_ID_BASE + 11'(ax_q) &&
                   o_tx_frame.dlc == `CSL_DLC && !o_tx_frame.ide)
    else $error("Command frame format wrong");
  a_send_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    st_q == csl_pkg::CSL_TX_SCAN && !send_en |=> !o_tx_valid)
    else $error("Frame sent for disabled axis");
  a_cmd_scaled: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    st_q == csl_pkg::CSL_TX_SCAN && send_en |=> o_tx_frame.data == $past(tx_counts))
    else $error("Command counts wrong");
  a_fb_routed: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    rx_hit |=> fb_q[$past(rx_idx)] == $past(rx_user))
    else $error("Feedback not stored");
  a_wd_refresh: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    refresh |=> wd_cnt_q == 32'h0 && !wd_exp_q)
    else $error("Watchdog not restarted");
  a_wd_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !ctrl_q[`CSL_F_WD_EN] |=> wd_cnt_q == 32'h0 && !wd_exp_q)
    else $error("Watchdog ran while disabled");
  a_pwr_cut: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    wd_exp_q |-> o_drive_pwr_en == 6'h0)
    else $error("Power on after expiry");
  a_pwr_cause: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_drive_pwr_en != 6'h0 |-> $past(ctrl_q[`CSL_F_PWR_REQ]) && !$past(i_power_fault))
    else $error("Power on without cause");
  a_wd_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == `CSL_A_STATUS |=> o_rdata[0] == $past(wd_exp_q))
    else $error("Expiry flag wrong");
  a_switch_inv: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == `CSL_A_SWITCH_N |=> o_rdata[17:0] == ~$past(sw_q))
    else $error("Inverted switches wrong");
  a_bit_rate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_can_bit_tick |-> ##BIT_CYC o_can_bit_tick)
    else $error("Bit tick period wrong");
  a_err_led: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    wd_exp_q |=> o_led_error)
    else $error("Error LED dark after expiry");
  a_boot_led: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_led_boot |-> $past(ctrl_q[`CSL_F_BOOT_OK]))
    else $error("Boot LED without start-up");
  c_frame_sent: cover property (@(posedge i_ref_clk) o_tx_valid && i_tx_ready);
  c_fb_rx: cover property (@(posedge i_ref_clk) rx_hit);
  c_wd_expire: cover property (@(posedge i_ref_clk) $rose(wd_exp_q));
endmodule

// ==== csl_supervisor_tb.sv ====
// Purpose: Self-checking bench for the servo link supervisor
// Assumes: Shortened send period and blink half period
// Notes:   Register traffic through the plain strobe port
`include "csl_params.svh"
module csl_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SP = 64;
  localparam int BH = 128;
  logic clk, rst, wr, rd, txv, txr, rxv, full, tick, pf, berr, slow;
  logic lcan, lerr, lboot, lapp;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, ex;
  logic [5:0]  refsw, low, up, pwr;
  logic [1:0]  estop;
  logic [2:0]  hi, lo;
  csl_pkg::csl_can_frame_t txf, rxf;
  int bad_count, n_checks, k;
  csl_supervisor #(.N_AXES(6), .SEND_PERIOD_CYC(SP), .BLINK_HALF_CYC(BH)) u_csl_supervisor (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_tx_frame(txf), .o_tx_valid(txv), .i_tx_ready(txr),
    .i_rx_frame(rxf), .i_rx_valid(rxv), .i_can_buf_full(full), .o_can_bit_tick(tick),
    .i_reference_switch_input(refsw), .i_lower_travel_limit(low),
    .i_upper_travel_limit(up), .i_estop(estop), .i_power_fault(pf),
    .i_host_bus_err(berr), .o_drive_pwr_en(pwr), .o_led_can(lcan), .o_led_error(lerr),
    .o_led_boot(lboot), .o_app_running_indicator(lapp));
  csl_amp_model u_csl_amp_model (.i_ref_clk(clk), .i_tx_frame(txf), .i_tx_valid(txv),
    .o_tx_ready(txr), .o_rx_frame(rxf), .o_rx_valid(rxv), .i_slow(slow));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    chk(nm, e, rdata);
  endtask
  // Collect which levels the CAN, error and app LEDs took over a span
  task automatic watch(input int n);
    hi = '0;
    lo = '0;
    repeat (n) begin
      @(posedge clk);
      hi = hi | {lcan, lerr, lapp};
      lo = lo | ~{lcan, lerr, lapp};
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(20000);
    bad_count++;
    summarize();
  end
  initial begin
    {rst, wr, rd, full, pf, berr, slow} = 7'h41;
    {addr, wdata, refsw, low, up, estop} = '0;
    bad_count = 0;
    n_checks = 0;
    cyc(16);
    rst <= 1'b0;
    rdc("ctrl", `CSL_A_CTRL, `CSL_RST_CTRL);
    rdc("wd_tmo", `CSL_A_WD_TMO, `CSL_RST_WD_TMO);
    rdc("scale5", 8'h54, `CSL_RST_SCALE);
    rdc("fbscale5", 8'h74, `CSL_RST_FBSCALE);
    rdc("unmapped", 8'hfc, 32'h0);
    rdc("axis6", 8'h98, 32'h0);
    wrr(`CSL_A_STATUS, 32'hffff_ffff);
    rdc("status", `CSL_A_STATUS, 32'h0000_00c0);
    refsw <= 6'h2d;
    low   <= 6'h13;
    up    <= 6'h3a;
    estop <= 2'b01;
    cyc(2);
    rdc("switch", `CSL_A_SWITCH, {14'h0, 6'h3a, 6'h13, 6'h2d});
    rdc("switch_n", `CSL_A_SWITCH_N, {14'h0, ~{6'h3a, 6'h13, 6'h2d}});
    rdc("estop", `CSL_A_STATUS, 32'h0000_0090);
    for (int n = 0; n < 6; n++) begin
      wrr(8'(8'h20 + 4 * n), 32'hfffd_8000);
      wrr(8'(8'h40 + 4 * n), 32'(n + 3));
    end
    wrr(`CSL_A_CTRL, 32'h0000_2500);
    cyc(2 * SP);
    slow <= 1'b0;
    watch(4 * BH);
    chk("can_blink", 32'h3, {30'h0, hi[2], lo[2]});
    cyc(SP);
    for (int n = 0; n < 6; n++) begin
      ex = 32'((longint'(32'shfffd_8000) * longint'(n + 3)) >>> 16);
      chk("sent", 32'((6'h25 >> n) & 1), 32'(u_csl_amp_model.n_rx[n] != 0));
      if ((6'h25 >> n) & 1) chk("cmd_data", ex, u_csl_amp_model.last[n]);
    end
    chk("frame_fmt", 32'h0, 32'(u_csl_amp_model.bad_fmt));
    wrr(`CSL_A_CTRL, 32'h0);
    cyc(4 * BH);
    watch(3 * BH);
    chk("can_idle", 32'h0, 32'(hi[2]));
    full <= 1'b1;
    cyc(2);
    watch(3 * BH);
    chk("can_full", 32'h2, {30'h0, hi[2], lo[2]});
    full <= 1'b0;
    wrr(8'h68, 32'h0000_8000);
    u_csl_amp_model.send(11'h022, 4'h4, 32'h0000_0064);
    u_csl_amp_model.send(11'h025, 4'h4, 32'hffff_fff6);
    u_csl_amp_model.send(11'h026, 4'h4, 32'h1);
    u_csl_amp_model.send(11'h021, 4'h3, 32'h7);
    rdc("fb2", 8'h88, 32'h0032_0000);
    rdc("fb5", 8'h94, 32'hfff6_0000);
    rdc("fb1", 8'h84, 32'h0);
    wrr(`CSL_A_WD_TMO, 32'd30);
    wrr(`CSL_A_CTRL, 32'h3);
    cyc(2);
    chk("pwr_on", 32'h3f, 32'(pwr));
    repeat (8) begin
      rdc("refresh", `CSL_A_SWITCH, {14'h0, 6'h3a, 6'h13, 6'h2d});
      cyc(7);
    end
    chk("pwr_fed", 32'h3f, 32'(pwr));
    cyc(40);
    chk("pwr_wd", 32'h0, 32'(pwr));
    rdc("expired", `CSL_A_STATUS, 32'h0000_0091);
    watch(3 * BH);
    chk("err_lit", 32'h2, {30'h0, hi[1], lo[1]});
    rdc("restart", `CSL_A_SWITCH, {14'h0, 6'h3a, 6'h13, 6'h2d});
    cyc(2);
    chk("pwr_back", 32'h3f, 32'(pwr));
    rdc("status_on", `CSL_A_STATUS, 32'h0000_0094);
    wrr(`CSL_A_CTRL, 32'h2);
    cyc(60);
    chk("wd_off", 32'h3f, 32'(pwr));
    pf <= 1'b1;
    cyc(2);
    chk("pwr_fault", 32'h0, 32'(pwr));
    rdc("status_pf", `CSL_A_STATUS, 32'h0000_0092);
    pf   <= 1'b0;
    berr <= 1'b1;
    cyc(1);
    berr <= 1'b0;
    rdc("bus_err", `CSL_A_CTRL, 32'h0000_0012);
    watch(4 * BH);
    chk("err_blink", 32'h3, {30'h0, hi[1], lo[1]});
    wrr(`CSL_A_CTRL, 32'h0000_001c);
    cyc(2);
    chk("boot_on", 32'h1, 32'(lboot));
    watch(4 * BH);
    chk("app_blink", 32'h3, {30'h0, hi[0], lo[0]});
    chk("err_clear", 32'h0, 32'(hi[1]));
    wrr(`CSL_A_CTRL, 32'h0);
    cyc(2);
    chk("boot_off", 32'h0, 32'(lboot));
    watch(3 * BH);
    chk("app_off", 32'h0, 32'(hi[0]));
    k = 0;
    while (tick !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (tick !== 1'b1 && k < 300);
    chk("bit_tick", 32'd125, 32'(k));
    summarize();
  end
endmodule
